// [verilog/cbcd_pkg.sv]
`default_nettype none
package cbcd_pkg;
   localparam logic [5:0] CMD_DRIVER_STAGE = 6'h04;
   localparam logic [5:0] CMD_IO_RESERVED  = 6'h05;
   localparam logic [5:0] CMD_SELECT       = 6'h07;
   localparam logic [5:0] CMD_IF_COND      = 6'h08;
   localparam logic [5:0] CMD_SEND_SPEC    = 6'h09;
   localparam logic [5:0] CMD_SEND_IDENT   = 6'h0a;
   localparam logic [5:0] CMD_VOLT_SWITCH  = 6'h0b;
   localparam logic [5:0] CMD_STOP         = 6'h0c;
   localparam logic [5:0] CMD_STATUS       = 6'h0d;
   localparam logic [5:0] CMD_RESERVED14   = 6'h0e;
   localparam logic [5:0] CMD_INACTIVE     = 6'h0f;
   // Argument field positions
   localparam int ADDR_MSB    = 31;
   localparam int ADDR_LSB    = 16;
   localparam int VOLT_MSB    = 11;
   localparam int VOLT_LSB    = 8;
   localparam int PATTERN_MSB = 7;
   localparam int TASK_BIT    = 15;
   // Reset value and accepted voltage code
   localparam logic [15:0] DRIVER_STAGE_RST = 16'h0404;
   localparam logic [3:0]  VOLT_SUPPORTED   = 4'h1;
   typedef enum logic [2:0] {
      CBCD_NONE, CBCD_R1, CBCD_R1B, CBCD_R2_SPEC, CBCD_R2_IDENT, CBCD_R7, CBCD_R1_TASK
   } cbcd_resp_t;
   typedef enum {
      CBCD_STANDBY, CBCD_TRANSFER, CBCD_SENDING, CBCD_PROGRAMMING, CBCD_DISCONNECT,
      CBCD_INACTIVE
   } cbcd_state_t;
endpackage
`default_nettype wire

// [verilog/cbcd_addr_match.sv]
`timescale 1ns/10ps
`default_nettype none
// Compares the address field of an argument with the card's own address
module cbcd_addr_match (
   input  wire logic [31:0] arg,     // Command argument
   input  wire logic [15:0] own_addr, // Published relative address
   output logic             hit,     // Address field equals own address
   output logic             zero     // Address field is zero
);
   // Only the address field is looked at; low bits are stuff
   assign hit  = (arg[cbcd_pkg::ADDR_MSB:cbcd_pkg::ADDR_LSB] == own_addr);
   assign zero = (arg[cbcd_pkg::ADDR_MSB:cbcd_pkg::ADDR_LSB] == 16'h0000);
endmodule
`default_nettype wire

// [verilog/cbcd_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
module cbcd_decoder (
   input  wire logic        clk,               // 100 MHz clock
   input  wire logic        nrst,              // Async reset, active low
   input  wire logic        cmd_valid,         // One-cycle command strobe
   input  wire logic [5:0]  cmd_index,         // Command index
   input  wire logic [31:0] cmd_arg,           // Command argument
   input  wire logic        addr_load,         // Pulse: new address published
   input  wire logic [15:0] addr_new,          // Address published by command 3
   input  wire logic        command_queuing,   // Queuing enabled
   input  wire logic        data_active,       // Data transfer running
   input  wire logic        program_busy,      // Programming running
   output logic             resp_valid,        // One-cycle answer strobe
   output logic [2:0]       resp_kind,         // Answer type
   output logic [7:0]       resp_pattern,      // Echoed check pattern
   output logic [3:0]       resp_voltage,      // Accepted voltage field
   output logic             stop_pulse,        // Pulse: end data transfer
   output logic [15:0]      driver_stage,      // Driver-stage register
   output logic [15:0]      relative_card_address, // Own address
   output logic             low_signalling,    // 1.8V signalling selected
   output logic [2:0]       card_state,        // Current card state
   output logic             illegal_cmd        // Pulse: unsupported index
);
   logic addr_hit;
   logic addr_zero;
   cbcd_pkg::cbcd_state_t state;
   logic volt_ok;

   cbcd_addr_match u_match (
      .arg      (cmd_arg),
      .own_addr (relative_card_address),
      .hit      (addr_hit),
      .zero     (addr_zero)
   );

   // Only one supply range is accepted; any other code leaves the card silent
   assign volt_ok = (cmd_arg[cbcd_pkg::VOLT_MSB:cbcd_pkg::VOLT_LSB] == cbcd_pkg::VOLT_SUPPORTED);

   // Own address follows command 3 publication
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         relative_card_address <= 16'h0000;
      end else if (addr_load) begin
         relative_card_address <= addr_new;
      end
   end

   // Driver-stage register; broadcast so no address check
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         driver_stage <= cbcd_pkg::DRIVER_STAGE_RST;
      end else if (cmd_valid && cmd_index == cbcd_pkg::CMD_DRIVER_STAGE
                   && state != cbcd_pkg::CBCD_INACTIVE) begin
         driver_stage <= cmd_arg[cbcd_pkg::ADDR_MSB:cbcd_pkg::ADDR_LSB];
      end
   end

   // Signalling level; stays low until reset since the switch is one-way
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_signalling <= 1'b0;
      end else if (cmd_valid && cmd_index == cbcd_pkg::CMD_VOLT_SWITCH
                   && state != cbcd_pkg::CBCD_INACTIVE) begin
         low_signalling <= 1'b1;
      end
   end

   // Card state machine
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= cbcd_pkg::CBCD_STANDBY;
      end else if (cmd_valid) begin
         case (cmd_index)
            cbcd_pkg::CMD_SELECT: begin
               case (state)
                  cbcd_pkg::CBCD_STANDBY: begin
                     if (addr_hit && !addr_zero) state <= cbcd_pkg::CBCD_TRANSFER;
                  end
                  cbcd_pkg::CBCD_TRANSFER, cbcd_pkg::CBCD_SENDING: begin
                     if (!addr_hit || addr_zero) state <= cbcd_pkg::CBCD_STANDBY;
                  end
                  cbcd_pkg::CBCD_PROGRAMMING: begin
                     if (!addr_hit || addr_zero) state <= cbcd_pkg::CBCD_DISCONNECT;
                  end
                  cbcd_pkg::CBCD_DISCONNECT: begin
                     if (addr_hit && !addr_zero) state <= cbcd_pkg::CBCD_PROGRAMMING;
                  end
                  default: state <= state;
               endcase
            end
            cbcd_pkg::CMD_STOP: begin
               if (state == cbcd_pkg::CBCD_SENDING) state <= cbcd_pkg::CBCD_TRANSFER;
            end
            cbcd_pkg::CMD_INACTIVE: begin
               if (addr_hit) state <= cbcd_pkg::CBCD_INACTIVE;
            end
            default: state <= state;
         endcase
      end else begin
         // Track data and programming activity reported by the data path
         case (state)
            cbcd_pkg::CBCD_TRANSFER: begin
               if (data_active) state <= cbcd_pkg::CBCD_SENDING;
               else if (program_busy) state <= cbcd_pkg::CBCD_PROGRAMMING;
            end
            cbcd_pkg::CBCD_SENDING: begin
               if (!data_active) state <= cbcd_pkg::CBCD_TRANSFER;
            end
            cbcd_pkg::CBCD_PROGRAMMING: begin
               if (!program_busy) state <= cbcd_pkg::CBCD_TRANSFER;
            end
            cbcd_pkg::CBCD_DISCONNECT: begin
               if (!program_busy) state <= cbcd_pkg::CBCD_STANDBY;
            end
            default: state <= state;
         endcase
      end
   end

   // Published state lags the internal state by one cycle so it comes from a flop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         card_state <= 3'h0;
      end else begin
         card_state <= 3'(state);
      end
   end

   // Answer selection; inactive cards stay silent
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resp_valid   <= 1'b0;
         resp_kind    <= 3'h0;
         resp_pattern <= 8'h00;
         resp_voltage <= 4'h0;
      end else begin
         resp_valid <= 1'b0;
         resp_kind  <= cbcd_pkg::CBCD_NONE;
         if (cmd_valid && state != cbcd_pkg::CBCD_INACTIVE) begin
            case (cmd_index)
               cbcd_pkg::CMD_SELECT: begin
                  // Only the card that ends up selected answers, with busy
                  if (addr_hit && !addr_zero) begin
                     resp_valid <= 1'b1;
                     resp_kind  <= cbcd_pkg::CBCD_R1B;
                  end
               end
               cbcd_pkg::CMD_IF_COND: begin
                  // Unsupported voltage: card stays silent
                  if (volt_ok) begin
                     resp_valid   <= 1'b1;
                     resp_kind    <= cbcd_pkg::CBCD_R7;
                     resp_pattern <= cmd_arg[cbcd_pkg::PATTERN_MSB:0];
                     resp_voltage <= cmd_arg[cbcd_pkg::VOLT_MSB:cbcd_pkg::VOLT_LSB];
                  end
               end
               cbcd_pkg::CMD_SEND_SPEC: begin
                  if (addr_hit) begin
                     resp_valid <= 1'b1;
                     resp_kind  <= cbcd_pkg::CBCD_R2_SPEC;
                  end
               end
               cbcd_pkg::CMD_SEND_IDENT: begin
                  if (addr_hit) begin
                     resp_valid <= 1'b1;
                     resp_kind  <= cbcd_pkg::CBCD_R2_IDENT;
                  end
               end
               cbcd_pkg::CMD_VOLT_SWITCH: begin
                  resp_valid <= 1'b1;
                  resp_kind  <= cbcd_pkg::CBCD_R1;
               end
               cbcd_pkg::CMD_STOP: begin
                  resp_valid <= 1'b1;
                  resp_kind  <= cbcd_pkg::CBCD_R1B;
               end
               cbcd_pkg::CMD_STATUS: begin
                  if (addr_hit) begin
                     resp_valid <= 1'b1;
                     if (command_queuing && cmd_arg[cbcd_pkg::TASK_BIT])
                        resp_kind <= cbcd_pkg::CBCD_R1_TASK;
                     else
                        resp_kind <= cbcd_pkg::CBCD_R1;
                  end
               end
               default: resp_valid <= 1'b0;
            endcase
         end
      end
   end

   // Stop request towards the data path
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stop_pulse <= 1'b0;
      end else begin
         stop_pulse <= cmd_valid && cmd_index == cbcd_pkg::CMD_STOP
                       && state != cbcd_pkg::CBCD_INACTIVE;
      end
   end

   // Unsupported index flag, no other effect
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         illegal_cmd <= 1'b0;
      end else begin
         illegal_cmd <= cmd_valid && (cmd_index == cbcd_pkg::CMD_IO_RESERVED
                        || cmd_index == cbcd_pkg::CMD_RESERVED14);
      end
   end

   AST_DRV_LOAD: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_DRIVER_STAGE && state != cbcd_pkg::CBCD_INACTIVE)
      |=> (driver_stage == $past(cmd_arg[31:16])) && !resp_valid)
      else $error("driver stage not loaded or answered");
   AST_SELECT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SELECT && state == cbcd_pkg::CBCD_STANDBY
       && addr_hit && !addr_zero) |=> state == cbcd_pkg::CBCD_TRANSFER)
      else $error("select did not reach transfer");
   AST_DESELECT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SELECT && state == cbcd_pkg::CBCD_TRANSFER
       && addr_zero) |=> state == cbcd_pkg::CBCD_STANDBY)
      else $error("zero address did not deselect");
   AST_IFCOND: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_IF_COND && volt_ok
       && state != cbcd_pkg::CBCD_INACTIVE)
      |=> resp_valid && resp_pattern == $past(cmd_arg[7:0]))
      else $error("check pattern not echoed");
   AST_SPEC: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SEND_SPEC && addr_hit
       && state != cbcd_pkg::CBCD_INACTIVE) |=> resp_kind == cbcd_pkg::CBCD_R2_SPEC)
      else $error("specific data not answered");
   AST_VOLT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_VOLT_SWITCH && state != cbcd_pkg::CBCD_INACTIVE)
      |=> low_signalling && resp_kind == cbcd_pkg::CBCD_R1)
      else $error("voltage switch failed");
   AST_TASK: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_STATUS && addr_hit && !command_queuing
       && state != cbcd_pkg::CBCD_INACTIVE) |=> resp_kind == cbcd_pkg::CBCD_R1)
      else $error("status kind wrong with queuing off");
   AST_INACTIVE: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_INACTIVE && addr_hit)
      |=> state == cbcd_pkg::CBCD_INACTIVE && !resp_valid ##1 $stable(state))
      else $error("deactivate failed");
   AST_RESERVED: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_RESERVED14) |=> illegal_cmd && !resp_valid)
      else $error("reserved index answered");

   // Select toggling and address publication
   AST_DISCONNECT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SELECT && state == cbcd_pkg::CBCD_PROGRAMMING
       && !addr_hit) |=> state == cbcd_pkg::CBCD_DISCONNECT)
      else $error("deselect in programming did not disconnect");
   AST_RESELECT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SELECT && state == cbcd_pkg::CBCD_DISCONNECT
       && addr_hit && !addr_zero) |=> state == cbcd_pkg::CBCD_PROGRAMMING
      && resp_valid && resp_kind == cbcd_pkg::CBCD_R1B)
      else $error("reselect did not resume programming");
   AST_OTHER_ADDR: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SELECT && state == cbcd_pkg::CBCD_TRANSFER
       && !addr_hit) |=> state == cbcd_pkg::CBCD_STANDBY && !resp_valid)
      else $error("other address did not deselect silently");
   AST_ADDR_LOAD: assert property (@(posedge clk) disable iff (!nrst)
      addr_load |=> relative_card_address == $past(addr_new))
      else $error("published address not taken");

   // Answers and silences of the voltage check and the addressed commands
   AST_IFCOND_MISS: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_IF_COND && !volt_ok) |=> !resp_valid)
      else $error("unsupported voltage answered");
   AST_IDENT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SEND_IDENT && addr_hit
       && state != cbcd_pkg::CBCD_INACTIVE) |=> resp_valid && resp_kind == cbcd_pkg::CBCD_R2_IDENT)
      else $error("identification not answered");
   AST_IDENT_MISS: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_SEND_IDENT && !addr_hit) |=> !resp_valid)
      else $error("identification answered for another address");
   AST_TASK_ON: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_STATUS && addr_hit && command_queuing
       && cmd_arg[cbcd_pkg::TASK_BIT] && state != cbcd_pkg::CBCD_INACTIVE)
      |=> resp_valid && resp_kind == cbcd_pkg::CBCD_R1_TASK)
      else $error("task status not answered");
   AST_STATUS_ON: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_STATUS && addr_hit && command_queuing
       && !cmd_arg[cbcd_pkg::TASK_BIT] && state != cbcd_pkg::CBCD_INACTIVE)
      |=> resp_valid && resp_kind == cbcd_pkg::CBCD_R1)
      else $error("plain status not answered with queuing on");

   // Stop, reserved indices and the inactive card
   AST_STOP: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_STOP && state != cbcd_pkg::CBCD_INACTIVE)
      |=> stop_pulse && resp_valid && resp_kind == cbcd_pkg::CBCD_R1B)
      else $error("stop not answered with busy");
   AST_STOP_STATE: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_STOP
       && (state == cbcd_pkg::CBCD_SENDING || state == cbcd_pkg::CBCD_TRANSFER))
      |=> state == cbcd_pkg::CBCD_TRANSFER)
      else $error("stop did not end the transfer");
   AST_RES5: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_index == cbcd_pkg::CMD_IO_RESERVED)
      |=> illegal_cmd && !resp_valid && $stable(state))
      else $error("reserved index changed the card");
   AST_SILENT: assert property (@(posedge clk) disable iff (!nrst)
      (cmd_valid && state == cbcd_pkg::CBCD_INACTIVE) |=> !resp_valid && !stop_pulse)
      else $error("inactive card answered");
endmodule
`default_nettype wire

// [verif/cbcd_host.sv]
`timescale 1ns/10ps
`default_nettype none
// Host controller model: one command at a time, answer captured at its edge
module cbcd_host (
   input  wire logic        clk,          // Bus clock
   output logic             cmd_valid,    // Command strobe
   output logic [5:0]       cmd_index,    // Command index
   output logic [31:0]      cmd_arg,      // Command argument
   output logic             addr_load,    // Address publish strobe
   output logic [15:0]      addr_new,     // Address chosen by command 3
   input  wire logic        resp_valid,   // Answer strobe
   input  wire logic [2:0]  resp_kind,    // Answer type
   input  wire logic [7:0]  resp_pattern, // Echoed pattern
   input  wire logic [3:0]  resp_voltage, // Echoed voltage field
   input  wire logic        stop_pulse,   // Stop strobe
   input  wire logic        illegal_cmd   // Unsupported strobe
);
   logic [15:0] got_valid;
   logic [15:0] got_kind;
   logic [15:0] got_echo;
   logic [15:0] got_stop;
   logic [15:0] got_illegal;
   // Idle bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_index = 6'h00;
      cmd_arg = 32'h0000_0000;
      addr_load = 1'b0;
      addr_new = 16'h0000;
   end
   // Strobes are one cycle; pulses of the answer stand one cycle only
   task automatic send(input logic [5:0] idx, input logic [31:0] arg);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_index <= idx;
      cmd_arg <= arg;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_index <= ~idx;
      cmd_arg <= ~arg; // Released lines never keep a stale value
      #1;
      got_valid = 16'(resp_valid);
      got_kind = 16'(resp_kind);
      got_echo = {4'h0, resp_voltage, resp_pattern};
      got_stop = 16'(stop_pulse);
      got_illegal = 16'(illegal_cmd);
   endtask
   // Command 3 happens outside the block; only its result is published
   task automatic publish(input logic [15:0] a);
      @(posedge clk);
      addr_load <= 1'b1;
      addr_new <= a;
      @(posedge clk);
      addr_load <= 1'b0;
      addr_new <= ~a;
      #1;
   endtask
   task automatic if_cond(input logic [3:0] v, input logic [7:0] p);
      send(6'h08, {20'h00000, v, p});
   endtask
   task automatic inactivate(input logic [15:0] addr);
      send(6'h0f, {addr, 16'h0000});
   endtask
   // Zero deselects any card; for a zero own address 0001 is sent instead
   task automatic deselect(input logic [15:0] addr);
      send(6'h07, {(addr == 16'h0000) ? 16'h0001 : 16'h0000, 16'h0000});
   endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk;
   logic        nrst;
   logic        queuing;
   logic        dact;
   logic        pbusy;
   logic        cmd_valid;
   logic [5:0]  cmd_index;
   logic [31:0] cmd_arg;
   logic        addr_load;
   logic [15:0] addr_new;
   logic        resp_valid;
   logic [2:0]  resp_kind;
   logic [7:0]  resp_pattern;
   logic [3:0]  resp_voltage;
   logic        stop_pulse;
   logic [15:0] driver_stage;
   logic [15:0] card_addr;
   logic        low_sig;
   logic [2:0]  card_state;
   logic        illegal_cmd;
   int          n_errors;
   int          comparisons;
   int          cycles;
   logic [5:0]  reserved_idx [2];
   cbcd_decoder u_dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
      .cmd_arg(cmd_arg), .addr_load(addr_load), .addr_new(addr_new), .command_queuing(queuing),
      .data_active(dact), .program_busy(pbusy), .resp_valid(resp_valid),
      .resp_kind(resp_kind), .resp_pattern(resp_pattern), .resp_voltage(resp_voltage),
      .stop_pulse(stop_pulse), .driver_stage(driver_stage), .relative_card_address(card_addr),
      .low_signalling(low_sig), .card_state(card_state), .illegal_cmd(illegal_cmd));
   cbcd_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
      .cmd_arg(cmd_arg), .addr_load(addr_load), .addr_new(addr_new),
      .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_pattern(resp_pattern),
      .resp_voltage(resp_voltage), .stop_pulse(stop_pulse), .illegal_cmd(illegal_cmd));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // State lags the answer by one more cycle
   task automatic settle;
      @(posedge clk);
      #1;
   endtask
   // Whole run is under a hundred cycles; a hang is cut well beyond that
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      nrst = 1'b0;
      queuing = 1'b0;
      dact = 1'b0;
      pbusy = 1'b0;
      n_errors = 0;
      comparisons = 0;
      cycles = 0;
      reserved_idx[0] = cbcd_pkg::CMD_IO_RESERVED;
      reserved_idx[1] = cbcd_pkg::CMD_RESERVED14;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      #1;
      check(driver_stage, 16'h0404);
      check(16'(card_state), 16'h0000);
      u_host.publish(16'h1234);
      check(card_addr, 16'h1234);
      u_host.send(cbcd_pkg::CMD_DRIVER_STAGE, 32'hbeef_5a5a);
      check(u_host.got_valid, 16'h0000);
      check(driver_stage, 16'hbeef);
      u_host.if_cond(4'h1, 8'haa);
      check(u_host.got_kind, 16'h0005);
      check(u_host.got_echo, 16'h01aa);
      u_host.if_cond(4'h2, 8'h55);
      check(u_host.got_valid, 16'h0000);
      u_host.send(cbcd_pkg::CMD_SEND_SPEC, 32'h1234_ffff);
      check(u_host.got_kind, 16'h0003);
      u_host.send(cbcd_pkg::CMD_SEND_IDENT, 32'h1234_0000);
      check(u_host.got_kind, 16'h0004);
      u_host.send(cbcd_pkg::CMD_SEND_IDENT, 32'h1235_0000);
      check(u_host.got_valid, 16'h0000);
      u_host.send(cbcd_pkg::CMD_STATUS, 32'h1234_8000);
      check(u_host.got_kind, 16'h0001);
      queuing <= 1'b1;
      u_host.send(cbcd_pkg::CMD_STATUS, 32'h1234_8000);
      check(u_host.got_kind, 16'h0006);
      u_host.send(cbcd_pkg::CMD_STATUS, 32'h1234_7fff);
      check(u_host.got_kind, 16'h0001);
      u_host.send(cbcd_pkg::CMD_VOLT_SWITCH, 32'h0000_0000);
      check(u_host.got_kind, 16'h0001);
      check(16'(low_sig), 16'h0001);
      // Both reserved indices: strobe only, no answer, no state change
      foreach (reserved_idx[i]) begin
         u_host.send(reserved_idx[i], 32'h1234_0000);
         check(u_host.got_illegal, 16'h0001);
         check(u_host.got_valid, 16'h0000);
         settle();
         check(16'(card_state), 16'h0000);
      end
      u_host.send(cbcd_pkg::CMD_SELECT, 32'h1234_0000);
      check(u_host.got_kind, 16'h0002);
      settle();
      check(16'(card_state), 16'h0001);
      dact <= 1'b1;
      u_host.send(cbcd_pkg::CMD_STOP, 32'hffff_ffff);
      check(u_host.got_stop, 16'h0001);
      check(u_host.got_kind, 16'h0002);
      check(16'(card_state), 16'h0002);
      dact <= 1'b0;
      settle();
      check(16'(card_state), 16'h0001);
      u_host.deselect(card_addr);
      settle();
      check(16'(card_state), 16'h0000);
      u_host.send(cbcd_pkg::CMD_SELECT, 32'h1234_0000);
      u_host.send(cbcd_pkg::CMD_SELECT, 32'h4321_0000);
      check(u_host.got_valid, 16'h0000);
      settle();
      check(16'(card_state), 16'h0000);
      // Programming and disconnect toggle on select while the data path is busy
      u_host.send(cbcd_pkg::CMD_SELECT, 32'h1234_0000);
      pbusy <= 1'b1;
      u_host.send(cbcd_pkg::CMD_SELECT, 32'h4321_0000);
      check(16'(card_state), 16'h0003);
      u_host.send(cbcd_pkg::CMD_SELECT, 32'h1234_0000);
      check(u_host.got_kind, 16'h0002);
      check(16'(card_state), 16'h0004);
      pbusy <= 1'b0;
      settle();
      settle();
      check(16'(card_state), 16'h0001);
      u_host.deselect(card_addr);
      u_host.inactivate(16'h9999);
      settle();
      check(16'(card_state), 16'h0000);
      u_host.inactivate(16'h1234);
      check(u_host.got_valid, 16'h0000);
      settle();
      check(16'(card_state), 16'h0005);
      u_host.send(cbcd_pkg::CMD_STATUS, 32'h1234_0000);
      check(u_host.got_valid, 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire
